// ---- hw/picdsr_pkg.sv ----
// register map, field positions, reset values and timing for the phy management block
package picdsr_pkg;
   // register addresses on the management interface
   localparam logic [4:0] REG_INT_CS = 5'h1B;
   localparam logic [4:0] REG_CABLE = 5'h1D;
   localparam logic [4:0] REG_PHY_CTL1 = 5'h1E;
   localparam logic [4:0] REG_PHY_CTL2 = 5'h1F;
   // field positions
   localparam int INT_EN_LSB = 8;
   localparam int INT_FLAG_LSB = 0;
   localparam int CAB_START_BIT = 15;
   localparam int CAB_RES_LSB = 13;
   localparam int CAB_SHORT_BIT = 12;
   localparam int CAB_RSV_LSB = 9;
   localparam int CAB_CNT_LSB = 0;
   localparam int CTL1_PAUSE_BIT = 9;
   localparam int CTL1_LINK_BIT = 8;
   localparam int CTL1_POL_BIT = 7;
   localparam int CTL1_MDIX_BIT = 5;
   localparam int CTL2_INT_LVL_BIT = 9;
   // reset values
   localparam logic [7:0] INT_EN_RESET = 8'h00;
   localparam logic [7:0] INT_FLAG_RESET = 8'h00;
   localparam logic INT_LVL_RESET = 1'b0;
   localparam logic INT_OUT_RESET = 1'b1;
   localparam logic [2:0] CAB_RSV_RESET = 3'h0;
   localparam logic [8:0] FAULT_CNT_RESET = 9'h000;
   // management frame
   localparam logic [4:0] PHY_ADDR_DEFAULT = 5'h00;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam int PREAMBLE_BITS = 32;
   localparam int HDR_BITS = 13;
   localparam int DATA_BITS = 16;
   localparam int WTA_BITS = 2;
   // timing
   localparam int CLK_MHZ = 250;
   localparam int DIAG_TIMEOUT_US = 100;
   localparam int DIAG_TIMEOUT_CYC = DIAG_TIMEOUT_US * CLK_MHZ;
   localparam int FAULT_CNT_W = 9;
   localparam logic [8:0] SHORT_LIMIT_DEFAULT = 9'h00A;
   typedef enum logic [1:0] {DIAG_NORMAL, DIAG_OPEN, DIAG_SHORT, DIAG_FAILED} picdsr_diag_res_t;
   typedef enum logic [2:0] {MS_IDLE, MS_HDR, MS_TA1, MS_TA2, MS_RDATA, MS_WTA,
      MS_WDATA} picdsr_mstate_t;
endpackage

// ---- hw/picdsr_diag_if.sv ----
// interface between register logic and cable diagnostic engine
`timescale 1ns/1ps
interface picdsr_diag_if;
   logic start;
   logic busy;
   picdsr_pkg::picdsr_diag_res_t result;
   logic short_ind;
   logic [picdsr_pkg::FAULT_CNT_W-1:0] fault_cnt;
   modport ctrl (output start, input busy, input result, input short_ind, input fault_cnt);
   modport engine (input start, output busy, output result, output short_ind, output fault_cnt);
endinterface // picdsr_diag_if

// ---- hw/picdsr_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module picdsr_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input logic mclk,
   input logic reset,
   // asynchronous in, synchronous out
   input logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } picdsr_sync_st_t;
   picdsr_sync_st_t st_q;
   picdsr_sync_st_t st_d;
   always_comb begin
      st_d.meta = async_in;
      st_d.stable = st_q.meta;
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign sync_out = st_q.stable;
endmodule // picdsr_sync

// ---- hw/picdsr_diag.sv ----
// cable diagnostic engine with timeout
`timescale 1ns/1ps
module picdsr_diag
   import picdsr_pkg::*;
#(
   parameter int TIMEOUT_CYC = picdsr_pkg::DIAG_TIMEOUT_CYC,
   parameter logic [8:0] SHORT_LIMIT = picdsr_pkg::SHORT_LIMIT_DEFAULT
) (
   // clock and reset
   input logic mclk,
   input logic reset,
   // control side
   picdsr_diag_if.engine d,
   // analog front end
   output logic tdr_fire,
   input logic tdr_done,
   input picdsr_pkg::picdsr_diag_res_t tdr_code,
   input logic [picdsr_pkg::FAULT_CNT_W-1:0] tdr_dist
);
   localparam int TW = $clog2(TIMEOUT_CYC + 1);
   typedef struct packed {
      logic busy;
      logic fire;
      logic [TW-1:0] timer;
      picdsr_diag_res_t result;
      logic short_ind;
      logic [FAULT_CNT_W-1:0] fault_cnt;
   } picdsr_diag_st_t;
   picdsr_diag_st_t st_q;
   picdsr_diag_st_t st_d;
   always_comb begin
      st_d = st_q;
      st_d.fire = 1'b0;
      if (!st_q.busy) begin
         if (d.start) begin
            st_d.busy = 1'b1;
            st_d.fire = 1'b1;
            st_d.timer = '0;
         end
      end else if (tdr_done) begin
         st_d.busy = 1'b0;
         st_d.result = tdr_code;
         st_d.fault_cnt = tdr_dist;
         st_d.short_ind = (tdr_code == DIAG_SHORT) && (tdr_dist < SHORT_LIMIT);
      end else if (st_q.timer == TW'(TIMEOUT_CYC - 1)) begin
         st_d.busy = 1'b0;
         st_d.result = DIAG_FAILED;
         st_d.short_ind = 1'b0;
         st_d.fault_cnt = FAULT_CNT_RESET;
      end else begin
         st_d.timer = st_q.timer + 1'b1;
      end
   end
   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q <= '0;
         st_q.result <= DIAG_NORMAL;
         st_q.fault_cnt <= FAULT_CNT_RESET;
      end else begin
         st_q <= st_d;
      end
   end
   assign d.busy = st_q.busy;
   assign d.result = st_q.result;
   assign d.short_ind = st_q.short_ind;
   assign d.fault_cnt = st_q.fault_cnt;
   assign tdr_fire = st_q.fire;
   chk_done_result: assert property (
      @(posedge mclk) disable iff (reset)
      (st_q.busy && tdr_done) |=> (!st_q.busy && st_q.result == $past(tdr_code)
         && st_q.fault_cnt == $past(tdr_dist)))
      else $error("diagnostic result not captured");
   chk_short_ind: assert property (
      @(posedge mclk) disable iff (reset)
      $fell(st_q.busy) |-> (st_q.short_ind == ((st_q.result == DIAG_SHORT)
         && (st_q.fault_cnt < SHORT_LIMIT))))
      else $error("short cable indicator wrong");
   chk_diag_timeout: assert property (
      @(posedge mclk) disable iff (reset)
      (st_q.busy && !tdr_done && st_q.timer == TW'(TIMEOUT_CYC - 1))
         |=> (!st_q.busy && st_q.result == DIAG_FAILED))
      else $error("diagnostic timeout not reported as failed");
endmodule // picdsr_diag

// ---- hw/picdsr_top.sv ----
// phy interrupt, cable diagnostic and status registers behind the management serial port
`timescale 1ns/1ps
module picdsr_top
   import picdsr_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = picdsr_pkg::PHY_ADDR_DEFAULT,
   parameter int DIAG_TIMEOUT_CYC = picdsr_pkg::DIAG_TIMEOUT_CYC,
   parameter logic [8:0] SHORT_LIMIT = picdsr_pkg::SHORT_LIMIT_DEFAULT
) (
   // clock and reset
   input logic mclk,
   input logic reset,
   // management serial pins
   input logic mdc,
   input logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   // interrupt pin
   output logic int_out,
   // events from the phy core, one-cycle pulses
   input logic [7:0] phy_events,
   // status from the phy core
   input logic pause_capable,
   input logic link_up,
   input logic polarity_rev,
   input logic mdix_state,
   // cable diagnostic front end
   output logic tdr_fire,
   input logic tdr_done,
   input picdsr_pkg::picdsr_diag_res_t tdr_code,
   input logic [picdsr_pkg::FAULT_CNT_W-1:0] tdr_dist
);
   import picdsr_pkg::*;

   typedef struct packed {
      picdsr_mstate_t ms;
      logic [5:0] ones;
      logic [4:0] cnt;
      logic [HDR_BITS-1:0] hdr;
      logic [DATA_BITS-1:0] sh;
      logic [4:0] addr;
      logic mdio_o;
      logic mdio_oe;
      logic mdc_d;
      logic [7:0] int_en;
      logic [7:0] int_flag;
      logic int_lvl;
      logic [2:0] cab_rsv;
      logic int_out;
      logic diag_start;
   } picdsr_top_st_t;

   picdsr_top_st_t st_q;
   picdsr_top_st_t st_d;
   logic [1:0] pins_s;
   logic mdc_s;
   logic mdio_s;
   logic mdc_rise;
   logic rd_hit;
   logic wr_hit;
   logic int_clr;
   logic int_pend;
   logic [HDR_BITS-1:0] hdr_full;
   logic [DATA_BITS-1:0] wword;
   logic [DATA_BITS-1:0] rword;
   logic [7:0] wr_en_field;

   // pin synchronisers
   picdsr_sync #(
      .WIDTH(2)
   ) u_sync (
      .mclk(mclk),
      .reset(reset),
      .async_in({mdc, mdio_i}),
      .sync_out(pins_s)
   );
   assign mdc_s = pins_s[1];
   assign mdio_s = pins_s[0];

   // cable diagnostic engine
   picdsr_diag_if diag ();
   picdsr_diag #(
      .TIMEOUT_CYC(DIAG_TIMEOUT_CYC),
      .SHORT_LIMIT(SHORT_LIMIT)
   ) u_diag (
      .mclk(mclk),
      .reset(reset),
      .d(diag.engine),
      .tdr_fire(tdr_fire),
      .tdr_done(tdr_done),
      .tdr_code(tdr_code),
      .tdr_dist(tdr_dist)
   );
   assign diag.start = st_q.diag_start;

   assign mdc_rise = mdc_s && !st_q.mdc_d;
   assign hdr_full = {st_q.hdr[HDR_BITS-2:0], mdio_s};
   assign wword = {st_q.sh[DATA_BITS-2:0], mdio_s};
   assign wr_en_field = wword[INT_EN_LSB +: 8];

   // read data decode
   always_comb begin
      rword = 16'h0000;
      if (st_q.addr == REG_INT_CS) begin
         rword[INT_EN_LSB +: 8] = st_q.int_en;
         rword[INT_FLAG_LSB +: 8] = st_q.int_flag;
      end else if (st_q.addr == REG_CABLE) begin
         rword[CAB_START_BIT] = st_q.diag_start | diag.busy;
         rword[CAB_RES_LSB +: 2] = diag.result;
         rword[CAB_SHORT_BIT] = diag.short_ind;
         rword[CAB_RSV_LSB +: 3] = st_q.cab_rsv;
         rword[CAB_CNT_LSB +: FAULT_CNT_W] = diag.fault_cnt;
      end else if (st_q.addr == REG_PHY_CTL1) begin
         rword[CTL1_PAUSE_BIT] = pause_capable;
         rword[CTL1_LINK_BIT] = link_up;
         rword[CTL1_POL_BIT] = polarity_rev;
         rword[CTL1_MDIX_BIT] = mdix_state;
      end else if (st_q.addr == REG_PHY_CTL2) begin
         rword[CTL2_INT_LVL_BIT] = st_q.int_lvl;
      end
   end

   // frame engine and register update
   always_comb begin
      st_d = st_q;
      st_d.mdc_d = mdc_s;
      st_d.diag_start = 1'b0;
      rd_hit = 1'b0;
      wr_hit = 1'b0;
      if (mdc_rise) begin
         case (st_q.ms)
            MS_IDLE: begin
               if (mdio_s) begin
                  if (st_q.ones != 6'h3F) begin
                     st_d.ones = st_q.ones + 6'h01;
                  end
               end else begin
                  if (st_q.ones >= 6'(PREAMBLE_BITS)) begin
                     st_d.ms = MS_HDR;
                     st_d.cnt = 5'h00;
                  end
                  st_d.ones = 6'h00;
               end
            end
            MS_HDR: begin
               st_d.hdr = hdr_full;
               st_d.cnt = st_q.cnt + 5'h01;
               if (st_q.cnt == 5'(HDR_BITS - 1)) begin
                  st_d.addr = hdr_full[4:0];
                  st_d.cnt = 5'h00;
                  if (!hdr_full[12] || hdr_full[9:5] != PHY_ADDR) begin
                     st_d.ms = MS_IDLE;
                  end else if (hdr_full[11:10] == OP_READ) begin
                     st_d.ms = MS_TA1;
                  end else if (hdr_full[11:10] == OP_WRITE) begin
                     st_d.ms = MS_WTA;
                  end else begin
                     st_d.ms = MS_IDLE;
                  end
               end
            end
            MS_TA1: begin
               rd_hit = 1'b1;
               st_d.sh = rword;
               st_d.mdio_oe = 1'b1;
               st_d.mdio_o = 1'b0;
               st_d.ms = MS_TA2;
            end
            MS_TA2: begin
               st_d.mdio_o = st_q.sh[DATA_BITS-1];
               st_d.sh = {st_q.sh[DATA_BITS-2:0], 1'b0};
               st_d.cnt = 5'h00;
               st_d.ms = MS_RDATA;
            end
            MS_RDATA: begin
               if (st_q.cnt == 5'(DATA_BITS - 1)) begin
                  st_d.mdio_oe = 1'b0;
                  st_d.mdio_o = 1'b0;
                  st_d.ms = MS_IDLE;
               end else begin
                  st_d.mdio_o = st_q.sh[DATA_BITS-1];
                  st_d.sh = {st_q.sh[DATA_BITS-2:0], 1'b0};
                  st_d.cnt = st_q.cnt + 5'h01;
               end
            end
            MS_WTA: begin
               st_d.cnt = st_q.cnt + 5'h01;
               if (st_q.cnt == 5'(WTA_BITS - 1)) begin
                  st_d.cnt = 5'h00;
                  st_d.ms = MS_WDATA;
               end
            end
            MS_WDATA: begin
               st_d.sh = wword;
               st_d.cnt = st_q.cnt + 5'h01;
               if (st_q.cnt == 5'(DATA_BITS - 1)) begin
                  wr_hit = 1'b1;
                  st_d.ms = MS_IDLE;
               end
            end
            default: begin
               st_d.ms = MS_IDLE;
            end
         endcase
      end
      if (wr_hit) begin
         if (st_q.addr == REG_INT_CS) begin
            st_d.int_en = wr_en_field;
         end else if (st_q.addr == REG_CABLE) begin
            st_d.cab_rsv = wword[CAB_RSV_LSB +: 3];
            if (wword[CAB_START_BIT] && !diag.busy) begin
               st_d.diag_start = 1'b1;
            end
         end else if (st_q.addr == REG_PHY_CTL2) begin
            st_d.int_lvl = wword[CTL2_INT_LVL_BIT];
         end
      end
      int_clr = rd_hit && (st_q.addr == REG_INT_CS);
      // new events win over the clear on read
      st_d.int_flag = (st_q.int_flag & ~{8{int_clr}}) | phy_events;
      int_pend = |(st_q.int_flag & st_q.int_en);
      st_d.int_out = int_pend ? st_q.int_lvl : ~st_q.int_lvl;
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         st_q <= '0;
         st_q.ms <= MS_IDLE;
         st_q.int_en <= INT_EN_RESET;
         st_q.int_flag <= INT_FLAG_RESET;
         st_q.int_lvl <= INT_LVL_RESET;
         st_q.cab_rsv <= CAB_RSV_RESET;
         st_q.int_out <= INT_OUT_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign mdio_o = st_q.mdio_o;
   assign mdio_oe = st_q.mdio_oe;
   assign int_out = st_q.int_out;

   // checks
   chk_flag_capture: assert property (
      @(posedge mclk) disable iff (reset)
      (|phy_events) |=> ((st_q.int_flag & $past(phy_events)) == $past(phy_events)))
      else $error("event flag not set");
   chk_read_clears: assert property (
      @(posedge mclk) disable iff (reset)
      (rd_hit && st_q.addr == REG_INT_CS && phy_events == 8'h00)
         |=> (st_q.int_flag == 8'h00))
      else $error("flags not cleared by status read");
   chk_flag_holds: assert property (
      @(posedge mclk) disable iff (reset)
      !(rd_hit && st_q.addr == REG_INT_CS)
         |=> ((st_q.int_flag & $past(st_q.int_flag)) == $past(st_q.int_flag)))
      else $error("flag dropped without status read");
   chk_int_active: assert property (
      @(posedge mclk) disable iff (reset)
      (|(st_q.int_flag & st_q.int_en)) |=> (int_out == $past(st_q.int_lvl)))
      else $error("interrupt not asserted at programmed level");
   chk_int_quiet: assert property (
      @(posedge mclk) disable iff (reset)
      !(|(st_q.int_flag & st_q.int_en)) |=> (int_out != $past(st_q.int_lvl)))
      else $error("interrupt asserted without enabled flag");
   chk_enable_write: assert property (
      @(posedge mclk) disable iff (reset)
      (wr_hit && st_q.addr == REG_INT_CS) |=> (st_q.int_en == $past(wr_en_field)))
      else $error("interrupt enables not written");
   chk_diag_start: assert property (
      @(posedge mclk) disable iff (reset)
      (wr_hit && st_q.addr == REG_CABLE && wword[CAB_START_BIT] && !diag.busy)
         |=> st_q.diag_start ##1 diag.busy)
      else $error("diagnostic did not start");
   chk_pending_reads: assert property (
      @(posedge mclk) disable iff (reset)
      (mdc_rise && st_q.ms == MS_TA1 && st_q.addr == REG_CABLE && diag.busy)
         |=> st_q.sh[CAB_START_BIT])
      else $error("pending test not read as one");
   chk_status_bits: assert property (
      @(posedge mclk) disable iff (reset)
      (mdc_rise && st_q.ms == MS_TA1 && st_q.addr == REG_PHY_CTL1)
         |=> (st_q.sh[CTL1_PAUSE_BIT] == $past(pause_capable)
         && st_q.sh[CTL1_POL_BIT] == $past(polarity_rev)))
      else $error("control one status bits wrong");
   chk_ta_drive: assert property (
      @(posedge mclk) disable iff (reset)
      (mdc_rise && st_q.ms == MS_TA1) |=> (mdio_oe && !mdio_o))
      else $error("turnaround zero not driven");
   chk_rd_release: assert property (
      @(posedge mclk) disable iff (reset)
      (mdc_rise && st_q.ms == MS_RDATA && st_q.cnt == 5'(DATA_BITS - 1)) |=> !mdio_oe)
      else $error("data line not released after read");
   chk_reset_values: assert property (
      @(posedge mclk) disable iff (reset)
      $fell(reset) |-> (st_q.int_en == INT_EN_RESET && st_q.int_flag == INT_FLAG_RESET
         && st_q.int_lvl == INT_LVL_RESET && int_out == INT_OUT_RESET))
      else $error("register not at reset value");
   chk_flag_no_spur: assert property (
      @(posedge mclk) disable iff (reset)
      (phy_events == 8'h00) |=> ((st_q.int_flag & ~$past(st_q.int_flag)) == 8'h00))
      else $error("event flag set without event");
   chk_level_write: assert property (
      @(posedge mclk) disable iff (reset)
      (wr_hit && st_q.addr == REG_PHY_CTL2)
         |=> (st_q.int_lvl == $past(wword[CTL2_INT_LVL_BIT])))
      else $error("interrupt level not written");
   chk_start_busy: assert property (
      @(posedge mclk) disable iff (reset)
      (wr_hit && st_q.addr == REG_CABLE && diag.busy) |=> !st_q.diag_start)
      else $error("diagnostic restarted while busy");
   chk_cable_fields: assert property (
      @(posedge mclk) disable iff (reset)
      (mdc_rise && st_q.ms == MS_TA1 && st_q.addr == REG_CABLE)
         |=> (st_q.sh[CAB_RES_LSB +: 2] == $past(diag.result)
         && st_q.sh[CAB_SHORT_BIT] == $past(diag.short_ind)
         && st_q.sh[CAB_CNT_LSB +: FAULT_CNT_W] == $past(diag.fault_cnt)))
      else $error("diagnostic fields not read back");
   chk_read_shift: assert property (
      @(posedge mclk) disable iff (reset)
      (mdc_rise && (st_q.ms == MS_TA2 || st_q.ms == MS_RDATA)
         && st_q.cnt != 5'(DATA_BITS - 1))
         |=> (mdio_oe && mdio_o == $past(st_q.sh[DATA_BITS-1])))
      else $error("read data bit not driven");
endmodule // picdsr_top

// ---- sim/picdsr_mac_model.sv ----
// station management master model driving the phy management pins
`timescale 1ns/1ps
module picdsr_mac_model (
   // clock
   input wire logic mclk,
   // management pins
   output logic mdc,
   output logic mdio_i,
   input wire logic mdio_o,
   input wire logic mdio_oe
);
   import picdsr_pkg::*;
   int half = 8;
   logic [4:0] phy = PHY_ADDR_DEFAULT;
   logic drv_en = 1'b0;
   logic drv_d = 1'b1;

   // line pulled up when nobody drives
   assign mdio_i = mdio_oe ? mdio_o : (drv_en ? drv_d : 1'b1);

   initial mdc = 1'b0;

   // one bit: data set while mdc low, line sampled at the rise
   task automatic bit_cyc(input logic d, input logic en, output logic s);
      @(posedge mclk);
      mdc <= 1'b0;
      drv_d <= d;
      drv_en <= en;
      repeat (half) @(posedge mclk);
      s = mdio_i;
      mdc <= 1'b1;
      repeat (half - 1) @(posedge mclk);
   endtask

   task automatic shift_out(input logic [31:0] v, input int n);
      logic s;
      for (int i = n - 1; i >= 0; i--) bit_cyc(v[i], 1'b1, s);
   endtask

   task automatic mdio_write(input logic [4:0] r, input logic [15:0] v);
      shift_out(32'hFFFFFFFF, PREAMBLE_BITS);
      shift_out({18'h00000, 2'h1, OP_WRITE, phy, r}, 14);
      shift_out({14'h0000, 2'h2, v}, 18);
   endtask

   task automatic mdio_read(input logic [4:0] r, output logic [15:0] v);
      logic s;
      shift_out(32'hFFFFFFFF, PREAMBLE_BITS);
      shift_out({18'h00000, 2'h1, OP_READ, phy, r}, 14);
      bit_cyc(1'b1, 1'b0, s);
      bit_cyc(1'b1, 1'b0, s);
      for (int i = 15; i >= 0; i--) begin
         bit_cyc(1'b1, 1'b0, s);
         v[i] = s;
      end
   endtask
endmodule // picdsr_mac_model

// ---- sim/tb.sv ----
// self-checking bench for the phy interrupt, diagnostic and status registers
`timescale 1ns/1ps
module tb;
   import picdsr_pkg::*;
   localparam int DIAG_CYC = 2500;
   localparam int FE_DELAY = 2000;
   localparam int LIMIT = 100000;
   logic mclk;
   logic reset = 1'b1;
   logic mdc;
   logic mdio_i;
   logic mdio_o;
   logic mdio_oe;
   logic int_out;
   logic [7:0] phy_events = 8'h00;
   logic [3:0] st = 4'h0;
   logic tdr_fire;
   logic tdr_done = 1'b0;
   picdsr_diag_res_t tdr_code = DIAG_NORMAL;
   logic [8:0] tdr_dist = 9'h000;
   logic fe_answer = 1'b0;
   logic [1:0] fe_code = 2'h0;
   logic [8:0] fe_dist = 9'h000;
   int fails = 0;
   int cmp_count = 0;
   int cyc = 0;
   // answer flag, result code, distance
   logic [11:0] cases [6] = '{12'hB23, 12'h840, 12'hC09, 12'hC0A, 12'hFFF, 12'h600};

   picdsr_top #(.DIAG_TIMEOUT_CYC(DIAG_CYC)) dut (
      .mclk(mclk), .reset(reset), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o),
      .mdio_oe(mdio_oe), .int_out(int_out), .phy_events(phy_events),
      .pause_capable(st[3]), .link_up(st[2]), .polarity_rev(st[1]), .mdix_state(st[0]),
      .tdr_fire(tdr_fire), .tdr_done(tdr_done), .tdr_code(tdr_code), .tdr_dist(tdr_dist));

   picdsr_mac_model mac (
      .mclk(mclk), .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic results;
      if (fails == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   always @(posedge mclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         fails++;
         results();
      end
   end

   // analog front end: answers late, then scrambles the released result lines
   initial begin
      forever begin
         @(posedge mclk);
         if (tdr_fire === 1'b1 && fe_answer) begin
            repeat (FE_DELAY) @(posedge mclk);
            tdr_code <= picdsr_diag_res_t'(fe_code);
            tdr_dist <= fe_dist;
            tdr_done <= 1'b1;
            @(posedge mclk);
            tdr_done <= 1'b0;
            tdr_code <= picdsr_diag_res_t'(~fe_code);
            tdr_dist <= ~fe_dist;
         end
      end
   end

   initial begin
      logic [15:0] v;
      logic [15:0] en;
      logic lvl;
      logic a;
      logic sh;
      int n;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      repeat (4) @(posedge mclk);
      check({15'h0000, int_out}, 16'h0001); // idle level
      mac.mdio_read(REG_INT_CS, v);
      check(v, 16'h0000); // reset value
      mac.mdio_read(REG_CABLE, v);
      check(v, 16'h0000); // reset value
      // each event alone, permitted or blocked, both pin polarities
      for (int p = 0; p < 2; p++) begin
         lvl = p[0];
         mac.mdio_write(REG_PHY_CTL2, {6'h00, lvl, 9'h000});
         for (int i = 0; i < 8; i++) begin
            a = ((i + p) % 2 == 0);
            en = a ? (16'h0100 << i) : (16'hFF00 & ~(16'h0100 << i));
            mac.mdio_write(REG_INT_CS, en | 16'h00FF);
            @(posedge mclk);
            phy_events <= 8'h01 << i;
            @(posedge mclk);
            phy_events <= 8'h00;
            repeat (3) @(posedge mclk);
            check({15'h0000, int_out}, {15'h0000, a ~^ lvl});
            mac.mdio_read(REG_INT_CS, v);
            check(v, (en & 16'hFF00) | (16'h0001 << i));
            repeat (4) @(posedge mclk);
            check({15'h0000, int_out}, {15'h0000, ~lvl}); // released
         end
      end
      mac.mdio_read(REG_INT_CS, v);
      check(v, 16'h8000); // flags cleared
      // live status bits
      for (int k = 0; k < 2; k++) begin
         st <= (k == 1) ? 4'hA : 4'h5;
         repeat (2) @(posedge mclk);
         mac.mdio_read(REG_PHY_CTL1, v);
         check(v, (k == 1) ? 16'h0280 : 16'h0120);
      end
      mac.mdio_read(5'h10, v);
      check(v, 16'h0000); // unmapped reads zero
      mac.phy = 5'h03;
      mac.mdio_write(REG_INT_CS, 16'hFF00);
      mac.mdio_read(REG_INT_CS, v);
      check(v, 16'hFFFF); // foreign address, line stays pulled up
      mac.phy = PHY_ADDR_DEFAULT;
      mac.mdio_read(REG_INT_CS, v);
      check(v, 16'h8000); // foreign write dropped
      // reserved op code, frame must be ignored
      mac.shift_out(32'hFFFFFFFF, PREAMBLE_BITS);
      mac.shift_out({18'h00000, 2'h1, 2'h3, PHY_ADDR_DEFAULT, REG_INT_CS}, 14);
      mac.shift_out({14'h0000, 2'h2, 16'h0000}, 18);
      mac.mdio_read(REG_INT_CS, v);
      check(v, 16'h8000); // enables kept
      // cable diagnostic, slower master
      mac.half = 12;
      for (int t = 0; t < 6; t++) begin
         {fe_answer, fe_code, fe_dist} = cases[t];
         sh = (fe_code == 2'h2 && fe_dist < SHORT_LIMIT_DEFAULT);
         mac.mdio_write(REG_CABLE, 16'h8E00);
         mac.mdio_read(REG_CABLE, v);
         check(v & 16'h8000, 16'h8000); // pending
         n = 0;
         while (v[15] !== 1'b0 && n < 8) begin
            mac.mdio_read(REG_CABLE, v);
            n++;
         end
         check(v, {1'b0, fe_code, sh, 3'h7, fe_dist});
      end
      results();
   end
endmodule // tb
